// ### common/uart_pkg.sv
// Purpose: Constants for the serial receive/transmit block with status and buffers
// Assumes: Avalon-MM slave, 32-bit words, byte addresses
// Notes:   Word offsets are byte addresses
//
// Overview of operation
// - Overrun flag sets when new character lands while buffer still unread.
// - Error summary sets on any error; one detail error flag always accompanies it (here a character rejected while error interrupt enable is clear sets no flags).
// - Wake-up enable set: only address characters raise the receive flag.
// - Wake-up plus no error interrupt: errored address character raises nothing.
// - Address indicator shows character type: 0 data, 1 address.
// - Divisor is low byte then high byte; valid from 3 up to FFFF.
// - Eight modulation bits add one source clock per bit where set.
// - Receive buffer holds last complete character, readable by software.
// - Seven-bit mode: receive data right-justified, top bit reads zero.
// - Transmit buffer holds character until moved into shift register and sent.
// - Any write to transmit buffer clears the transmit flag.
// - Seven-bit mode: transmitter ignores top bit; it reads as zero.
// - Parity error checked only when parity enabled, on every character.
package uart_pkg;
  localparam logic [4:0] ADDR_RX_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_BAUD_LO   = 5'h04;
  localparam logic [4:0] ADDR_BAUD_HI   = 5'h08;
  localparam logic [4:0] ADDR_MOD       = 5'h0C;
  localparam logic [4:0] ADDR_RX_BUF    = 5'h10;
  localparam logic [4:0] ADDR_TX_BUF    = 5'h14;
  localparam logic [4:0] ADDR_ENABLE    = 5'h18;
  localparam logic [4:0] ADDR_CONFIG    = 5'h1C;
  // Control/status bit positions
  localparam int FE_BIT     = 7;
  localparam int PE_BIT     = 6;
  localparam int OE_BIT     = 5;
  localparam int BRK_BIT    = 4;
  localparam int EIE_BIT    = 3;
  localparam int WIE_BIT    = 2;
  localparam int WAKE_BIT   = 1;
  localparam int ERR_BIT    = 0;
  // Enable register
  localparam int TXE_BIT    = 7;
  localparam int RXE_BIT    = 6;
  // Config register: parity enable, parity even, 8-bit char, address-bit mode
  localparam int PARITY_ENABLE_BIT   = 3;
  localparam int PEV_BIT    = 2;
  localparam int CHAR8_BIT  = 1;
  localparam int ADDRM_BIT  = 0;
  // Interrupt status/mask: rx flag bit 0, tx flag bit 1
  localparam logic [5:0] ADDR_IRQ_STAT  = 6'h20;
  localparam logic [5:0] ADDR_IRQ_MASK  = 6'h24;
  localparam logic [7:0] RX_CTRL_RESET  = 8'h00;
  localparam logic [7:0] CONFIG_RESET   = 8'h02;
  localparam logic [15:0] BAUD_RESET    = 16'h0010;
  localparam logic [15:0] BAUD_MIN      = 16'h0003;
  localparam logic [15:0] BAUD_MAX      = 16'hFFFF;
  localparam logic [7:0] MOD_RESET      = 8'h00;
endpackage

// ### rtl/uart_rx_status_and_buffers.sv
// Purpose: Serial transceiver with receive status, buffers and Avalon-MM registers
// Assumes: Line input synchronous to mclk; mclk is the baud source clock
// Notes:   Interrupt flags at 0x20 (status, write-one-clear) and 0x24 (mask)
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module uart_rx_status_and_buffers
  import uart_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line,
  output logic             irq
);

  typedef enum {S_IDLE, S_START, S_DATA, S_ADDR, S_PAR, S_STOP} ser_state_t;

  logic [7:0]  rx_ctrl;
  logic [7:0]  cfg;
  logic [15:0] baud_divisor;
  logic [7:0]  modulation_pattern;
  logic [7:0]  receive_data_buffer;
  logic [7:0]  transmit_data_buffer;
  logic [7:0]  module_enable_one;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        rx_buf_full;
  logic        tx_buf_full;
  logic        ack;

  // Bit period with modulation: one extra clock where pattern bit is set
  function automatic logic [16:0] bit_len(input logic [15:0] div, input logic [7:0] pat,
                                          input logic [3:0] idx);
    bit_len = {1'b0, div} + {16'h0000, pat[idx[2:0]]};
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic a, input logic am,
                                  input logic even, input logic c8);
    logic p;
    p = ^d[6:0] ^ (c8 & d[7]) ^ (am & a);
    par_of = even ? p : ~p;
  endfunction

  wire logic c8       = cfg[CHAR8_BIT];
  wire logic am       = cfg[ADDRM_BIT];
  wire logic [3:0] nbits = c8 ? 4'h8 : 4'h7;
  wire logic wr_acc   = write & ack & byteenable[0];
  wire logic rd_acc   = read & ~ack;
  wire logic rx_buf_rd = read & ack & (address == {1'b0, ADDR_RX_BUF});
  wire logic tx_buf_wr = wr_acc & (address == {1'b0, ADDR_TX_BUF});
  wire logic tx_en    = module_enable_one[TXE_BIT];
  wire logic rx_en    = module_enable_one[RXE_BIT];

  // One wait state; writes and read side effects land on the answering edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end
  assign waitrequest = (read | write) & ~ack;

  // Receiver
  ser_state_t  rx_st;
  logic [16:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [7:0]  rx_sh;
  logic        rx_addr;
  logic        rx_pe;
  logic        rx_done;
  logic        rx_fe;
  logic        rx_brk;
  wire logic [3:0] next_rx_idx = (rx_st == S_DATA) ? rx_idx + 4'h1 : rx_idx;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st   <= S_IDLE;
      rx_cnt  <= 17'h00000;
      rx_idx  <= 4'h0;
      rx_sh   <= 8'h00;
      rx_addr <= 1'b0;
      rx_pe   <= 1'b0;
      rx_done <= 1'b0;
      rx_fe   <= 1'b0;
      rx_brk  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_en) begin
        rx_st <= S_IDLE;
      end else begin
        case (rx_st)
          S_IDLE: begin
            if (!serial_rx_line) begin
              rx_st  <= S_START;
              rx_cnt <= {2'b00, baud_divisor[15:1]};
              rx_idx <= 4'h0;
              rx_sh  <= 8'h00;
              rx_brk <= 1'b1;
            end
          end
          default: begin
            if (rx_cnt != 17'h00000) begin
              rx_cnt <= rx_cnt - 17'h00001;
            end else begin
              rx_cnt <= bit_len(baud_divisor, modulation_pattern, next_rx_idx);
              rx_brk <= rx_brk & ~serial_rx_line;
              case (rx_st)
                S_START: begin
                  rx_st <= serial_rx_line ? S_IDLE : S_DATA;
                end
                S_DATA: begin
                  rx_sh[rx_idx[2:0]] <= serial_rx_line;
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == nbits - 4'h1) begin
                    rx_st <= am ? S_ADDR : (cfg[PARITY_ENABLE_BIT] ? S_PAR : S_STOP);
                  end
                end
                S_ADDR: begin
                  rx_addr <= serial_rx_line;
                  rx_st   <= cfg[PARITY_ENABLE_BIT] ? S_PAR : S_STOP;
                end
                S_PAR: begin
                  rx_pe <= serial_rx_line != par_of(rx_sh, rx_addr, am, cfg[PEV_BIT],
                                                    c8);
                  rx_st <= S_STOP;
                end
                default: begin
                  rx_fe   <= ~serial_rx_line;
                  rx_done <= 1'b1;
                  rx_st   <= S_IDLE;
                  if (!cfg[PARITY_ENABLE_BIT]) begin
                    rx_pe <= 1'b0;
                  end
                  if (!am) begin
                    rx_addr <= 1'b0;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  wire logic brk_now  = rx_brk & ~serial_rx_line;
  wire logic oe_now   = rx_buf_full & ~rx_buf_rd;
  wire logic err_now  = rx_fe | rx_pe | oe_now | brk_now;
  // Overrun is not a fault of the character itself, so it never rejects one
  wire logic char_err = rx_fe | rx_pe | brk_now;
  wire logic accept   = ~char_err | rx_ctrl[EIE_BIT];
  wire logic flag_ok  = accept & (~rx_ctrl[WIE_BIT] | rx_addr);
  wire logic rx_event = rx_done & flag_ok;

  // Receive status register; hardware set beats read clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_ctrl <= RX_CTRL_RESET;
    end else begin
      if (rx_buf_rd) begin
        rx_ctrl[FE_BIT]   <= 1'b0;
        rx_ctrl[PE_BIT]   <= 1'b0;
        rx_ctrl[OE_BIT]   <= 1'b0;
        rx_ctrl[BRK_BIT]  <= 1'b0;
        rx_ctrl[WAKE_BIT] <= 1'b0;
        rx_ctrl[ERR_BIT]  <= 1'b0;
      end else if (wr_acc && address == {1'b0, ADDR_RX_CTRL}) begin
        rx_ctrl <= writedata[7:0];
      end
      // Error bits stay set until the buffer is read or this register is written, so an overrun keeps older causes
      if (rx_done && accept) begin
        if (rx_fe) begin
          rx_ctrl[FE_BIT] <= 1'b1;
        end
        if (rx_pe) begin
          rx_ctrl[PE_BIT] <= 1'b1;
        end
        if (oe_now) begin
          rx_ctrl[OE_BIT] <= 1'b1;
        end
        if (brk_now) begin
          rx_ctrl[BRK_BIT] <= 1'b1;
        end
        if (err_now) begin
          rx_ctrl[ERR_BIT] <= 1'b1;
        end
        rx_ctrl[WAKE_BIT] <= rx_addr;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      receive_data_buffer <= 8'h00;
      rx_buf_full         <= 1'b0;
    end else begin
      if (rx_done && accept) begin
        receive_data_buffer <= c8 ? rx_sh : {1'b0, rx_sh[6:0]};
        rx_buf_full         <= 1'b1;
      end else if (rx_buf_rd) begin
        rx_buf_full <= 1'b0;
      end
    end
  end

  // Transmitter
  ser_state_t  tx_st;
  logic [16:0] tx_cnt;
  logic [3:0]  tx_idx;
  logic [7:0]  tx_sh;
  logic        tx_load;

  assign tx_load = tx_en && tx_st == S_IDLE && tx_buf_full && !tx_buf_wr;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_data_buffer <= 8'h00;
      tx_buf_full          <= 1'b0;
    end else begin
      if (tx_buf_wr) begin
        transmit_data_buffer <= c8 ? writedata[7:0] : {1'b0, writedata[6:0]};
        tx_buf_full          <= 1'b1;
      end else if (tx_load) begin
        tx_buf_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st          <= S_IDLE;
      tx_cnt         <= 17'h00000;
      tx_idx         <= 4'h0;
      tx_sh          <= 8'h00;
      serial_tx_line <= 1'b1;
    end else begin
      if (!tx_en) begin
        tx_st          <= S_IDLE;
        serial_tx_line <= 1'b1;
      end else if (tx_load) begin
        tx_sh          <= transmit_data_buffer;
        tx_st          <= S_START;
        tx_idx         <= 4'h0;
        tx_cnt         <= bit_len(baud_divisor, modulation_pattern, 4'h0);
        serial_tx_line <= 1'b0;
      end else if (tx_st != S_IDLE) begin
        if (tx_cnt != 17'h00000) begin
          tx_cnt <= tx_cnt - 17'h00001;
        end else begin
          tx_cnt <= bit_len(baud_divisor, modulation_pattern, tx_idx);
          case (tx_st)
            S_START: begin
              tx_st          <= S_DATA;
              serial_tx_line <= tx_sh[0];
              tx_idx         <= 4'h1;
            end
            S_DATA: begin
              if (tx_idx == nbits) begin
                if (am) begin
                  tx_st          <= S_ADDR;
                  serial_tx_line <= 1'b0;
                end else if (cfg[PARITY_ENABLE_BIT]) begin
                  tx_st          <= S_PAR;
                  serial_tx_line <= par_of(tx_sh, 1'b0, am, cfg[PEV_BIT], c8);
                end else begin
                  tx_st          <= S_STOP;
                  serial_tx_line <= 1'b1;
                end
              end else begin
                serial_tx_line <= tx_sh[tx_idx[2:0]];
                tx_idx         <= tx_idx + 4'h1;
              end
            end
            S_ADDR: begin
              tx_st          <= cfg[PARITY_ENABLE_BIT] ? S_PAR : S_STOP;
              serial_tx_line <= cfg[PARITY_ENABLE_BIT] ?
                                par_of(tx_sh, 1'b0, am, cfg[PEV_BIT], c8) : 1'b1;
            end
            S_PAR: begin
              tx_st          <= S_STOP;
              serial_tx_line <= 1'b1;
            end
            default: begin
              tx_st <= S_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      baud_divisor       <= BAUD_RESET;
      modulation_pattern <= MOD_RESET;
      module_enable_one  <= 8'h00;
      cfg                <= CONFIG_RESET;
      irq_mask           <= 2'h0;
    end else if (wr_acc) begin
      if (address == {1'b0, ADDR_BAUD_LO}) begin
        baud_divisor[7:0] <= writedata[7:0];
      end else if (address == {1'b0, ADDR_BAUD_HI}) begin
        baud_divisor[15:8] <= writedata[7:0];
      end else if (address == {1'b0, ADDR_MOD}) begin
        modulation_pattern <= writedata[7:0];
      end else if (address == {1'b0, ADDR_ENABLE}) begin
        module_enable_one <= {writedata[7:6], 6'h00};
      end else if (address == {1'b0, ADDR_CONFIG}) begin
        cfg <= {4'h0, writedata[3:0]};
      end else if (address == ADDR_IRQ_MASK) begin
        irq_mask <= writedata[1:0];
      end
    end
  end

  // Interrupt flags: rx bit 0, tx bit 1 (tx empty); set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= 2'h2;
    end else begin
      if (rx_buf_rd) begin
        irq_stat[0] <= 1'b0;
      end else if (wr_acc && address == ADDR_IRQ_STAT && writedata[0]) begin
        irq_stat[0] <= 1'b0;
      end
      if (rx_event) begin
        irq_stat[0] <= 1'b1;
      end
      if (tx_buf_wr) begin
        irq_stat[1] <= 1'b0;
      end else if (wr_acc && address == ADDR_IRQ_STAT && writedata[1]) begin
        irq_stat[1] <= 1'b0;
      end
      if (tx_load) begin
        irq_stat[1] <= 1'b1;
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Read data registered with the answer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h00000000;
    end else if (rd_acc) begin
      if (address == {1'b0, ADDR_RX_CTRL}) begin
        readdata <= {24'h000000, rx_ctrl};
      end else if (address == {1'b0, ADDR_BAUD_LO}) begin
        readdata <= {24'h000000, baud_divisor[7:0]};
      end else if (address == {1'b0, ADDR_BAUD_HI}) begin
        readdata <= {24'h000000, baud_divisor[15:8]};
      end else if (address == {1'b0, ADDR_MOD}) begin
        readdata <= {24'h000000, modulation_pattern};
      end else if (address == {1'b0, ADDR_RX_BUF}) begin
        readdata <= {24'h000000, receive_data_buffer};
      end else if (address == {1'b0, ADDR_TX_BUF}) begin
        readdata <= {24'h000000, transmit_data_buffer};
      end else if (address == {1'b0, ADDR_ENABLE}) begin
        readdata <= {24'h000000, module_enable_one};
      end else if (address == {1'b0, ADDR_CONFIG}) begin
        readdata <= {24'h000000, cfg};
      end else if (address == ADDR_IRQ_STAT) begin
        readdata <= {30'h0, irq_stat};
      end else if (address == ADDR_IRQ_MASK) begin
        readdata <= {30'h0, irq_mask};
      end else begin
        readdata <= 32'h00000000;
      end
    end
  end
endmodule

// ### verif/uart_status_checker.sv
// Purpose: Port-level checks for the serial status and buffer block
// Assumes: One wait state per bus request, byte registers in the low byte
// Notes:   Shadows track written settings so readback can be judged
`timescale 1ns/1ps
module uart_status_checker
  import uart_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        serial_rx_line,
  input wire logic        serial_tx_line,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [15:0] baud;
  logic [7:0]  mdl;
  logic        cfg8;
  logic        txe;
  wire         req   = read || write;
  wire         wdone = write && !waitrequest && byteenable[0];
  wire         rdone = read && !waitrequest;
  // Shadows take a write at the same edge at which it lands in the design
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      baud <= BAUD_RESET;
      mdl  <= MOD_RESET;
      cfg8 <= 1'b1;
      txe  <= 1'b0;
    end else if (wdone) begin
      if (address == 6'h04) baud[7:0] <= writedata[7:0];
      if (address == 6'h08) baud[15:8] <= writedata[7:0];
      if (address == 6'h0C) mdl <= writedata[7:0];
      if (address == 6'h1C) cfg8 <= writedata[1];
      if (address == 6'h18) txe <= writedata[7];
    end
  end
  a_wait_one:
    assert property (req && waitrequest |=> !waitrequest) else $error("wait too long");
  a_wait_first:
    assert property ($rose(req) |-> waitrequest) else $error("no wait state");
  a_rdata_hold:
    assert property (!read |=> $stable(readdata)) else $error("read data moved");
  a_irq_masked:
    assert property (wdone && address == 6'h24 && writedata[1:0] == 2'b00 |=> !irq)
      else $error("irq with all masked");
  a_err_summary:
    assert property (rdone && address == 6'h00 && readdata[0] |-> |readdata[7:4])
      else $error("summary without detail");
  a_read_clears:
    assert property (rdone && address == 6'h10 ##2 (read && address == 6'h00)[*2]
      |-> readdata[7:4] == 4'h0 && readdata[1:0] == 2'b00) else $error("flags kept");
  a_baud_back:
    assert property (rdone && (address == 6'h04 || address == 6'h08)
      |-> readdata[7:0] == (address == 6'h04 ? baud[7:0] : baud[15:8]))
      else $error("divisor readback");
  a_mod_back:
    assert property (rdone && address == 6'h0C |-> readdata[7:0] == mdl)
      else $error("modulation readback");
  a_rx7_msb:
    assert property (rdone && address == 6'h10 && !cfg8 |-> !readdata[7])
      else $error("seven-bit top bit set");
  a_tx_off:
    assert property (!txe |=> serial_tx_line) else $error("tx active while off");
  cover property (rdone && address == 6'h10);
  cover property (wdone && address == 6'h14);
  cover property ($rose(irq));
endmodule

// ### verif/serial_station.sv
// Purpose: Remote serial station feeding the receive line, capturing transmit
// Assumes: Bit time fixed by BIT_CLKS, line idles high
// Notes:   Frames with a low stop bit are dropped, not queued
`timescale 1ns/1ps
module serial_station #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic mclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [7:0] got_q[$];
  int         rx_bits = 8;
  initial rx_line = 1'b1;
  task automatic put(input logic b);
    rx_line <= b;
    repeat (BIT_CLKS) @(posedge mclk);
  endtask
  task automatic send(input logic [7:0] d, input int n, input bit xen, xb, stop);
    @(posedge mclk);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    if (xen) put(xb);
    put(stop);
    rx_line <= 1'b1;
  endtask
  // Mid-bit sampling keeps clear of the edges the sender moves on
  always begin
    logic [7:0] v;
    @(negedge tx_line);
    v = 8'h00;
    repeat (BIT_CLKS / 2) @(posedge mclk);
    for (int i = 0; i < rx_bits; i++) begin
      repeat (BIT_CLKS) @(posedge mclk);
      v[i] = tx_line;
    end
    repeat (BIT_CLKS) @(posedge mclk);
    if (tx_line === 1'b1) got_q.push_back(v);
  end
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench for the serial status and buffer block
// Assumes: Divisor 15 gives 16 clocks a bit, modulation left at zero
// Notes:   Expected bytes worked out here from the settings written
`timescale 1ns/1ps
module tb;
  logic        mclk, reset_n, read, write, irq, waitrequest, serial_rx_line, serial_tx_line;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic [15:0] seed;
  logic [7:0]  d, e, q;
  int          bad_count, num_checks;
  logic [5:0]  ra [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h18, 6'h1C, 6'h20, 6'h28};
  logic [7:0]  rv [8] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00};
  uart_rx_status_and_buffers uart_rx_status_and_buffers_i (.mclk(mclk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .serial_rx_line(serial_rx_line),
    .serial_tx_line(serial_tx_line), .irq(irq));
  serial_station #(.BIT_CLKS(16)) serial_station_i (.mclk(mclk), .tx_line(serial_tx_line),
    .rx_line(serial_rx_line));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic pick();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    d = {seed[7:1], 1'b1};
  endtask
  // Request held until a rising edge samples waitrequest low; data taken there
  task automatic bus(input bit wr, input logic [5:0] a, input logic [7:0] v);
    int n;
    @(posedge mclk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, v};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), x, q);
  endtask
  task automatic rx(input logic [7:0] v, input int n, input bit xen, xb, stop, flag);
    int k;
    serial_station_i.send(v, n, xen, xb, stop);
    for (k = 0; k < 40 && irq !== 1'b1; k++) @(negedge mclk);
    chk("irq", {7'h0, flag}, {7'h0, irq});
  endtask
  task automatic txwait(input int n);
    for (int k = 0; k < 600 && serial_station_i.got_q.size() < n; k++) @(posedge mclk);
    chk("tx count", n[7:0], 8'(serial_station_i.got_q.size()));
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {reset_n, read, write, address, writedata, bad_count, num_checks} = '0;
    seed = 16'h0010;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    pick();
    wr(6'h08, seed[15:8]);
    wr(6'h0C, seed[7:0]);
    rd(6'h08, seed[15:8]);
    rd(6'h0C, seed[7:0]);
    wr(6'h08, 8'h00);
    wr(6'h0C, 8'h00);
    wr(6'h04, 8'h0F);
    rd(6'h04, 8'h0F);
    wr(6'h18, 8'hC0);
    wr(6'h24, 8'h01);
    pick();
    rx(d, 8, 0, 0, 1, 1);
    rd(6'h20, 8'h03);
    wr(6'h24, 8'h00);
    wr(6'h20, 8'h01);
    rd(6'h20, 8'h02);
    wr(6'h24, 8'h01);
    wr(6'h10, ~d);
    rd(6'h10, d);
    rd(6'h00, 8'h00);
    e = d;
    pick();
    rx(e, 8, 0, 0, 1, 1);
    rx(d, 8, 0, 0, 1, 1);
    rd(6'h00, 8'h21);
    rd(6'h10, d);
    rd(6'h00, 8'h00);
    rd(6'h20, 8'h02);
    wr(6'h00, 8'h08);
    rx(d, 8, 0, 0, 0, 1);
    rd(6'h00, 8'h89);
    rd(6'h10, d);
    rx(8'h00, 8, 0, 0, 0, 1);
    rd(6'h00, 8'h99);
    rd(6'h10, 8'h00);
    wr(6'h00, 8'h00);
    rx(d, 8, 0, 0, 0, 0);
    rd(6'h00, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(6'h1C, p ? 8'h0E : 8'h0A);
      pick();
      rx(d, 8, 1, ^d ^ !p, 1, 1);
      rd(6'h00, 8'h00);
      rd(6'h10, d);
      wr(6'h00, 8'h08);
      rx(d, 8, 1, ^d ^ p, 1, 1);
      rd(6'h00, 8'h49);
      rd(6'h10, d);
      wr(6'h00, 8'h00);
    end
    wr(6'h1C, 8'h00);
    pick();
    rx(d, 7, 0, 0, 1, 1);
    rd(6'h10, {1'b0, d[6:0]});
    wr(6'h1C, 8'h03);
    wr(6'h00, 8'h04);
    e = d;
    pick();
    rx(e, 8, 1, 0, 1, 0);
    bus(1'b0, 6'h10, 8'h00);
    rx(d, 8, 1, 1, 1, 1);
    rd(6'h00, 8'h06);
    rd(6'h10, d);
    rx(d, 8, 1, 1, 0, 0);
    wr(6'h00, 8'h00);
    rx(e, 8, 1, 0, 1, 1);
    rd(6'h00, 8'h00);
    rd(6'h10, e);
    wr(6'h18, 8'h80);
    rx(d, 8, 1, 0, 1, 0);
    wr(6'h1C, 8'h02);
    wr(6'h18, 8'hC0);
    wr(6'h14, e);
    wr(6'h14, d);
    rd(6'h20, 8'h00);
    txwait(2);
    chk("tx byte", e, serial_station_i.got_q.pop_front());
    chk("tx byte", d, serial_station_i.got_q.pop_front());
    wr(6'h1C, 8'h00);
    serial_station_i.rx_bits = 7;
    wr(6'h14, 8'hA5);
    txwait(1);
    chk("tx byte", 8'h25, serial_station_i.got_q.pop_front());
    wr(6'h18, 8'h40);
    wr(6'h14, 8'h33);
    repeat (400) @(posedge mclk);
    txwait(0);
    complete_run();
  end
endmodule
bind uart_rx_status_and_buffers uart_status_checker uart_status_checker_i (.mclk(mclk),
  .reset_n(reset_n), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line), .irq(irq));
